// ---- sbl_top.sv ----
`timescale 1ns/1ps
module sbl_top #(
	parameter int EE_PROG_CYC = sbl_pkg::EE_PROG_CYC,
	parameter int FL_PROG_CYC = sbl_pkg::FL_PROG_CYC,
	parameter int ERASE_CYC = sbl_pkg::ERASE_CYC,
	// A smaller divisor only shortens simulation; the default gives 9600 baud
	parameter logic [9:0] BAUD_DIV = sbl_pkg::BAUD_DIV
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Serial link to the host
	input wire logic ser_rx,
	output logic ser_tx,
	// Flash and EEPROM arrays
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_write,
	output logic mem_read,
	output logic mem_erase,
	output logic mem_eeprom,
	input wire logic [7:0] mem_rdata
);
	sbl_pkg::sbl_top_t s_q, s_d;
	logic [7:0] rec_q [0:sbl_pkg::REC_MAX-1];
	logic rx_valid;
	logic [7:0] rx_data;
	logic tx_ready;
	logic [7:0] rl;
	logic [7:0] ch;
	logic buf_we;
	logic [7:0] buf_wd;

	function automatic logic is_hex(input logic [7:0] c);
		return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h61 && c <= 8'h66);
	endfunction

	function automatic logic [3:0] hex_val(input logic [7:0] c);
		return (c <= 8'h39) ? c[3:0] : c[3:0] + 4'h9;
	endfunction

	function automatic logic [7:0] msg_char(input logic [6:0] p);
		return sbl_pkg::MSG_ROM[8*(sbl_pkg::ROM_LEN-1-int'(p)) +: 8];
	endfunction

	sbl_uart #(.BAUD_DIV(BAUD_DIV)) u_uart (
		.clock(clock),
		.rst_n(rst_n),
		.rx(ser_rx),
		.tx(ser_tx),
		.tx_valid(s_q.tx_valid),
		.tx_data(s_q.tx_data),
		.tx_ready(tx_ready),
		.rx_valid(rx_valid),
		.rx_data(rx_data)
	);

	// Letters are folded to lower case so both cases decode alike
	assign rl = rx_data | 8'h20;
	assign ch = msg_char(s_q.ptr);
	assign buf_wd = {s_q.hi, hex_val(rl)};
	assign mem_addr = s_q.addr;
	assign mem_wdata = s_q.wdata;
	assign mem_write = s_q.wr;
	assign mem_read = s_q.rd;
	assign mem_erase = s_q.er;
	assign mem_eeprom = s_q.ee;

	always_comb begin
		s_d = s_q;
		s_d.tx_valid = 1'b0;
		s_d.wr = 1'b0;
		s_d.rd = 1'b0;
		s_d.er = 1'b0;
		buf_we = 1'b0;
		case (s_q.st)
			sbl_pkg::ST_MENU: begin
				s_d.ptr = sbl_pkg::MSG_MENU;
				s_d.nxt = sbl_pkg::ST_SELECT;
				s_d.st = sbl_pkg::ST_PRINT;
			end
			sbl_pkg::ST_PRINT: begin
				if (ch == 8'h00) begin
					s_d.st = s_q.nxt;
				end else if (tx_ready && !s_q.tx_valid) begin
					s_d.tx_valid = 1'b1;
					s_d.tx_data = ch;
					s_d.ptr = s_q.ptr + 7'h01;
				end
			end
			sbl_pkg::ST_SELECT: begin
				if (rx_valid) begin
					if (rl == sbl_pkg::CH_E || rl == sbl_pkg::CH_L) begin
						s_d.ee = (rl == sbl_pkg::CH_L);
						s_d.er = 1'b1;
						s_d.cnt = 20'(ERASE_CYC);
						s_d.st = sbl_pkg::ST_ERASE;
					end else if (rl == sbl_pkg::CH_P) begin
						s_d.ee = 1'b0;
						s_d.st = sbl_pkg::ST_PROMPT;
					end
				end
			end
			sbl_pkg::ST_ERASE: begin
				if (s_q.cnt == 20'h00000) begin
					s_d.addr = s_q.ee ? sbl_pkg::EE_LO : sbl_pkg::FL_LO;
					s_d.st = sbl_pkg::ST_VRD;
				end else begin
					s_d.cnt = s_q.cnt - 20'h00001;
				end
			end
			sbl_pkg::ST_VRD: begin
				s_d.rd = 1'b1;
				s_d.st = sbl_pkg::ST_VCHK;
			end
			sbl_pkg::ST_VCHK: begin
				if (mem_rdata != sbl_pkg::ERASED_BYTE) begin
					s_d.ptr = sbl_pkg::MSG_NOT_ERASED;
					s_d.nxt = sbl_pkg::ST_MENU;
					s_d.st = sbl_pkg::ST_PRINT;
				end else if (s_q.addr == (s_q.ee ? sbl_pkg::EE_HI : sbl_pkg::FL_HI)) begin
					if (s_q.ee) begin
						s_d.st = sbl_pkg::ST_PROMPT;
					end else begin
						s_d.ptr = sbl_pkg::MSG_ERASED;
						s_d.nxt = sbl_pkg::ST_MENU;
						s_d.st = sbl_pkg::ST_PRINT;
					end
				end else begin
					s_d.addr = s_q.addr + 16'h0001;
					s_d.st = sbl_pkg::ST_VRD;
				end
			end
			sbl_pkg::ST_PROMPT: begin
				s_d.ptr = sbl_pkg::MSG_STAR;
				s_d.nxt = sbl_pkg::ST_RECV;
				s_d.st = sbl_pkg::ST_PRINT;
				s_d.pos = 2'h0;
			end
			sbl_pkg::ST_RECV: begin
				if (!rx_valid) begin
					s_d.pos = s_q.pos;
				end else if (rx_data == sbl_pkg::CH_CR || rx_data == sbl_pkg::CH_LF) begin
					// A lone CR or LF between records is dropped
					if (s_q.pos != 2'h0) begin
						s_d.pos = 2'h0;
						if (s_q.rtype == sbl_pkg::REC_END) begin
							s_d.st = sbl_pkg::ST_MENU;
						end else if (s_q.rtype == sbl_pkg::REC_DATA && s_q.nb >= 7'h04) begin
							s_d.addr = {rec_q[1], rec_q[2]};
							s_d.idx = 7'h03;
							s_d.st = sbl_pkg::ST_PGM_LD;
						end else begin
							s_d.st = sbl_pkg::ST_PROMPT;
						end
					end
				end else if (s_q.pos == 2'h0) begin
					if (rl == sbl_pkg::CH_S) begin
						s_d.pos = 2'h1;
					end
				end else if (s_q.pos == 2'h1) begin
					s_d.rtype = hex_val(rl);
					s_d.pos = 2'h2;
					s_d.nb = 7'h00;
					s_d.hi_ok = 1'b0;
				end else if (is_hex(rl)) begin
					if (!s_q.hi_ok) begin
						s_d.hi = hex_val(rl);
						s_d.hi_ok = 1'b1;
					end else begin
						s_d.hi_ok = 1'b0;
						// Bytes past the buffer are dropped; longer records are illegal
						if (s_q.nb < 7'(sbl_pkg::REC_MAX)) begin
							buf_we = 1'b1;
							s_d.nb = s_q.nb + 7'h01;
						end
					end
				end
			end
			sbl_pkg::ST_PGM_LD: begin
				if ({1'b0, s_q.idx} >= rec_q[0]) begin
					s_d.st = sbl_pkg::ST_PROMPT;
				end else begin
					s_d.wdata = rec_q[s_q.idx];
					s_d.wr = 1'b1;
					s_d.cnt = s_q.ee ? 20'(EE_PROG_CYC) : 20'(FL_PROG_CYC);
					s_d.st = sbl_pkg::ST_PGM_WAIT;
				end
			end
			sbl_pkg::ST_PGM_WAIT: begin
				if (s_q.cnt == 20'h00000) begin
					s_d.rd = 1'b1;
					s_d.st = sbl_pkg::ST_PGM_CHK;
				end else begin
					s_d.cnt = s_q.cnt - 20'h00001;
				end
			end
			sbl_pkg::ST_PGM_CHK: begin
				if (mem_rdata != s_q.wdata) begin
					s_d.ptr = sbl_pkg::MSG_NOT_PROG;
					s_d.nxt = sbl_pkg::ST_MENU;
					s_d.st = sbl_pkg::ST_PRINT;
				end else begin
					s_d.addr = s_q.addr + 16'h0001;
					s_d.idx = s_q.idx + 7'h01;
					s_d.st = sbl_pkg::ST_PGM_LD;
				end
			end
			default: begin
				s_d.st = sbl_pkg::ST_MENU;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Record buffer needs no reset: it is only read after a full line filled it
	always_ff @(posedge clock) begin
		if (buf_we) begin
			rec_q[s_q.nb] <= buf_wd;
		end
	end

	// Checking logic
	logic [20:0] since_wr_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			since_wr_q <= '0;
		end else if (s_q.wr) begin
			since_wr_q <= 21'h000000;
		end else if (since_wr_q != 21'h1FFFFF) begin
			since_wr_q <= since_wr_q + 21'h000001;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_pick_p;
		s_q.st == sbl_pkg::ST_SELECT && rx_valid && rl == sbl_pkg::CH_P;
	endsequence

	sequence s_end_line;
		s_q.st == sbl_pkg::ST_RECV && rx_valid && s_q.pos != 2'h0 &&
			(rx_data == sbl_pkg::CH_CR || rx_data == sbl_pkg::CH_LF);
	endsequence

	sequence s_verify_bad;
		s_q.st == sbl_pkg::ST_VCHK && mem_rdata != sbl_pkg::ERASED_BYTE;
	endsequence

	a_menu_pick: assert property (s_pick_p |=> s_q.st == sbl_pkg::ST_PROMPT ##1
		s_q.ptr == sbl_pkg::MSG_STAR) else $error("P did not lead to prompt");
	a_star_recv: assert property (s_q.tx_valid && s_q.tx_data == sbl_pkg::CH_STAR
		|=> s_q.st == sbl_pkg::ST_RECV) else $error("no receive after star");
	a_s9_menu: assert property (s_end_line ##0 s_q.rtype == sbl_pkg::REC_END
		|=> s_q.st == sbl_pkg::ST_MENU) else $error("end record ignored");
	a_lone_eol: assert property (s_q.st == sbl_pkg::ST_RECV && rx_valid
		&& s_q.pos == 2'h0 && rx_data == sbl_pkg::CH_LF |=> s_q.st == sbl_pkg::ST_RECV)
		else $error("empty line not ignored");
	// The read follows the write strobe by the program time plus one cycle
	a_prog_wait: assert property (s_q.st == sbl_pkg::ST_PGM_CHK |->
		since_wr_q == 21'(s_q.ee ? EE_PROG_CYC : FL_PROG_CYC))
		else $error("program time wrong");
	a_erase_bad: assert property (s_verify_bad |=> s_q.ptr == sbl_pkg::MSG_NOT_ERASED
		&& s_q.nxt == sbl_pkg::ST_MENU) else $error("erase failure not reported");
	a_prog_bad: assert property (s_q.st == sbl_pkg::ST_PGM_CHK
		&& mem_rdata != s_q.wdata
		|=> s_q.ptr == sbl_pkg::MSG_NOT_PROG ##1 s_q.st == sbl_pkg::ST_PRINT)
		else $error("program failure not reported");
	a_verify_rng: assert property (mem_read && s_q.st == sbl_pkg::ST_VCHK |->
		(s_q.ee ? (s_q.addr >= sbl_pkg::EE_LO && s_q.addr <= sbl_pkg::EE_HI)
		: (s_q.addr >= sbl_pkg::FL_LO && s_q.addr <= sbl_pkg::FL_HI)))
		else $error("verify address out of range");
	a_ee_erase: assert property (s_q.st == sbl_pkg::ST_SELECT && rx_valid
		&& rl == sbl_pkg::CH_L
		|=> mem_erase && mem_eeprom) else $error("EEPROM erase not started");
	a_line_first: assert property (s_q.st == sbl_pkg::ST_RECV |-> !mem_write)
		else $error("write before line end");
endmodule

// ---- sbl_pkg.sv ----
// Notes on behaviour
// - Serial link runs at 9600 baud on both ends.
// - Characters framed as one start, eight data, no parity, one stop.
// - Baud divisor equals clock over sixteen times baud; 52 at 8.0 MHz.
// - Allow 10 ms per EEPROM byte, up to 3.5 ms per flash byte.
// - Show menu; accept E, P or L in either case.
// - CR, LF or both end a received line.
// - Erase bulk erases flash below F800, then reads every location back.
// - Report Erased if all read FF, else Not Erased; then menu.
// - Send asterisk when ready; host sends one record per asterisk.
// - Repeat until S9 record; otherwise wait forever, only reset escapes.
// - Flash byte failing readback reports Not Programmed, then menu.
// - Load-EE erases 0D00-0FFF, verifies FF, then starts record handshake.
package sbl_pkg;
	localparam int SYS_CLK_HZ = 100_000_000;
	localparam int CLK_MHZ = SYS_CLK_HZ / 1_000_000;
	localparam int BAUD_RATE = 9600;
	localparam int OVERSAMPLE = 16;
	// Divisor that an 8.0 MHz clock would need
	localparam int SERIAL_DIVISOR_DEFAULT = 52;
	localparam logic [9:0] BAUD_DIV = 10'(SYS_CLK_HZ / (OVERSAMPLE * BAUD_RATE));
	localparam int EE_PROG_US = 10_000;
	localparam int FL_PROG_US = 3_500;
	localparam int ERASE_US = 10_000;
	localparam int EE_PROG_CYC = EE_PROG_US * CLK_MHZ;
	localparam int FL_PROG_CYC = FL_PROG_US * CLK_MHZ;
	localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
	localparam logic [15:0] FL_LO = 16'h8000;
	localparam logic [15:0] FL_HI = 16'hF7FF;
	localparam logic [15:0] EE_LO = 16'h0D00;
	localparam logic [15:0] EE_HI = 16'h0FFF;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam int REC_MAX = 68;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_S = 8'h73;
	localparam logic [7:0] CH_E = 8'h65;
	localparam logic [7:0] CH_P = 8'h70;
	localparam logic [7:0] CH_L = 8'h6C;
	localparam logic [7:0] CH_STAR = 8'h2A;
	localparam logic [3:0] REC_DATA = 4'h1;
	localparam logic [3:0] REC_END = 4'h9;
	localparam int ROM_LEN = 78;
	localparam logic [8*ROM_LEN-1:0] MSG_ROM = {
		"\r\n(E)rase, (P)rogram or (L)oadEE: ", 8'h00,
		"\r\nErased", 8'h00, "\r\nNot Erased", 8'h00,
		"\r\nNot Programmed", 8'h00, "\r\n*", 8'h00};
	localparam logic [6:0] MSG_MENU = 7'h00;
	localparam logic [6:0] MSG_ERASED = 7'h23;
	localparam logic [6:0] MSG_NOT_ERASED = 7'h2C;
	localparam logic [6:0] MSG_NOT_PROG = 7'h39;
	localparam logic [6:0] MSG_STAR = 7'h4A;

	typedef enum logic [3:0] {
		ST_MENU = 4'h0, ST_PRINT = 4'h1, ST_SELECT = 4'h2, ST_ERASE = 4'h3,
		ST_VRD = 4'h4, ST_VCHK = 4'h5, ST_PROMPT = 4'h6, ST_RECV = 4'h7,
		ST_PGM_LD = 4'h8, ST_PGM_WAIT = 4'h9, ST_PGM_CHK = 4'hA
	} sbl_state_t;

	typedef struct packed {
		logic [9:0] div;
		logic [3:0] rx_tk;
		logic [3:0] rx_bit;
		logic rx_busy;
		logic [7:0] rx_sh;
		logic [7:0] rx_data;
		logic rx_valid;
		logic [3:0] tx_tk;
		logic [3:0] tx_bit;
		logic [9:0] tx_sh;
		logic tx_busy;
		logic tx_pin;
	} sbl_uart_t;

	typedef struct packed {
		sbl_state_t st;
		sbl_state_t nxt;
		logic [6:0] ptr;
		logic tx_valid;
		logic [7:0] tx_data;
		logic ee;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic er;
		logic [19:0] cnt;
		logic [1:0] pos;
		logic [3:0] rtype;
		logic hi_ok;
		logic [3:0] hi;
		logic [6:0] nb;
		logic [6:0] idx;
	} sbl_top_t;
endpackage

// ---- sbl_uart.sv ----
`timescale 1ns/1ps
module sbl_uart #(
	parameter logic [9:0] BAUD_DIV = sbl_pkg::BAUD_DIV
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Serial pins
	input wire logic rx,
	output logic tx,
	// Byte side
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic rx_valid,
	output logic [7:0] rx_data
);
	sbl_pkg::sbl_uart_t s_q, s_d;
	logic tick;

	assign tick = (s_q.div == BAUD_DIV - 10'h001);
	assign tx = s_q.tx_pin;
	assign tx_ready = !s_q.tx_busy;
	assign rx_valid = s_q.rx_valid;
	assign rx_data = s_q.rx_data;

	always_comb begin
		s_d = s_q;
		s_d.rx_valid = 1'b0;
		s_d.div = tick ? 10'h000 : s_q.div + 10'h001;
		if (!s_q.rx_busy) begin
			if (tick && !rx) begin
				s_d.rx_busy = 1'b1;
				s_d.rx_tk = 4'h0;
				s_d.rx_bit = 4'h0;
			end
		end else if (tick) begin
			s_d.rx_tk = s_q.rx_tk + 4'h1;
			if (s_q.rx_bit == 4'h0 && s_q.rx_tk == 4'h7) begin
				// A glitch shorter than half a bit is not a start bit
				s_d.rx_busy = !rx;
				s_d.rx_bit = 4'h1;
				s_d.rx_tk = 4'h0;
			end else if (s_q.rx_bit != 4'h0 && s_q.rx_tk == 4'hF) begin
				s_d.rx_bit = s_q.rx_bit + 4'h1;
				if (s_q.rx_bit == 4'h9) begin
					s_d.rx_busy = 1'b0;
					s_d.rx_valid = rx;
					s_d.rx_data = s_q.rx_sh;
				end else begin
					s_d.rx_sh = {rx, s_q.rx_sh[7:1]};
				end
			end
		end
		if (!s_q.tx_busy) begin
			if (tx_valid) begin
				s_d.tx_sh = {1'b1, tx_data, 1'b0};
				s_d.tx_busy = 1'b1;
				s_d.tx_bit = 4'h0;
				s_d.tx_tk = 4'h0;
			end
		end else if (tick) begin
			s_d.tx_tk = s_q.tx_tk + 4'h1;
			if (s_q.tx_tk == 4'hF) begin
				s_d.tx_sh = {1'b1, s_q.tx_sh[9:1]};
				s_d.tx_bit = s_q.tx_bit + 4'h1;
				s_d.tx_busy = (s_q.tx_bit != 4'h9);
			end
		end
		s_d.tx_pin = s_d.tx_busy ? s_d.tx_sh[0] : 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.tx_pin <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Checking logic: cycles since the last baud tick
	logic [9:0] gap_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gap_q <= 10'h000;
		end else if (tick) begin
			gap_q <= 10'h000;
		end else begin
			gap_q <= gap_q + 10'h001;
		end
	end

	a_baud_tick: assert property (@(posedge clock) disable iff (!rst_n)
		tick |-> gap_q == BAUD_DIV - 10'h001) else $error("baud tick spacing wrong");
endmodule

// ---- sbl_host.sv ----
`timescale 1ns/1ps
module sbl_host #(
	parameter logic [9:0] DIV = sbl_pkg::BAUD_DIV
) (
	// Clock
	input wire logic clock,
	// Serial pins
	input wire logic ser_tx,
	output logic ser_rx
);
	// One bit is sixteen divisor periods
	localparam int BIT_CYC = sbl_pkg::OVERSAMPLE * int'(DIV);
	logic [7:0] rxq[$];
	// Lines that had to go out without a prompt
	int late = 0;
	logic star_seen;
	logic [7:0] sh;
	initial begin
		ser_rx = 1'b1;
		star_seen = 1'b0;
	end
	// Sample each bit at its centre
	always begin
		@(negedge ser_tx);
		repeat (BIT_CYC / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clock);
			sh[i] = ser_tx;
		end
		repeat (BIT_CYC) @(posedge clock);
		// A bad stop bit poisons the char so the bench sees it
		if (ser_tx !== 1'b1) sh = 8'h00;
		if (sh == sbl_pkg::CH_STAR) star_seen = 1'b1;
		rxq.push_back(sh);
	end
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clock);
			ser_rx = f[i];
			repeat (BIT_CYC - 1) @(negedge clock);
		end
	endtask
	// A line goes out after a prompt, or after 1000 cycles without one, one line per prompt
	task automatic send_line(input string s);
		for (int i = 0; i < 1000 && !star_seen; i++) @(negedge clock);
		if (!star_seen) late++;
		star_seen = 1'b0;
		for (int i = 0; i < s.len(); i++) send_byte(s[i]);
	endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
	localparam int EE_CYC = 30;
	localparam int FL_CYC = 20;
	// Fast baud keeps the run short; both ends scale together
	localparam logic [9:0] DIV = 10'h002;
	localparam string MENU = "\r\n(E)rase, (P)rogram or (L)oadEE: ";
	localparam string STAR = "\r\n*";
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic ser_rx, ser_tx, mem_write, mem_read, mem_erase, mem_eeprom;
	logic [15:0] mem_addr;
	logic [7:0] mem_wdata, mem_rdata;
	logic [7:0] mem [0:65535];
	int miscompares = 0;
	int comparisons = 0;
	int cyc = 0;
	int wr_cyc = 0;
	logic wr_pend = 1'b0;
	logic wr_ee = 1'b0;
	logic bad_erase = 1'b0;
	logic [15:0] bad_prog = 16'h0000;
	sbl_top #(.EE_PROG_CYC(EE_CYC), .FL_PROG_CYC(FL_CYC), .ERASE_CYC(40), .BAUD_DIV(DIV)) dut (
		.clock(clock), .rst_n(rst_n), .ser_rx(ser_rx), .ser_tx(ser_tx),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_write(mem_write),
		.mem_read(mem_read), .mem_erase(mem_erase), .mem_eeprom(mem_eeprom),
		.mem_rdata(mem_rdata));
	sbl_host #(.DIV(DIV)) host (.clock(clock), .ser_tx(ser_tx), .ser_rx(ser_rx));
	always #5 clock = ~clock;
	assign mem_rdata = mem[mem_addr];
	always @(posedge clock) cyc <= cyc + 1;
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	// Array model; a fault flag keeps one flash and one EEPROM byte from erasing
	always @(posedge clock) begin
		if (mem_erase) begin
			for (int a = 0; a < 65536; a++) begin
				if (mem_eeprom ? (a >= 16'h0D00 && a <= 16'h0FFF) : (a >= 16'h8000 && a <= 16'hF7FF))
					mem[a] <= (bad_erase && (a == 16'h9000 || a == 16'h0E00)) ? 8'h00 : 8'hFF;
			end
		end
		if (mem_write) begin
			mem[mem_addr] <= (mem_addr == bad_prog) ? ~mem_wdata : mem_wdata;
			wr_cyc <= cyc;
			wr_ee <= mem_eeprom;
			wr_pend <= 1'b1;
		end
		if (mem_read && wr_pend) begin
			chk("program wait", (wr_ee ? EE_CYC : FL_CYC) + 1, cyc - wr_cyc);
			wr_pend <= 1'b0;
		end
		if (mem_read && !mem_eeprom) chk("verify range", 1, mem_addr < 16'hF800);
	end
	task automatic finish_test;
		chk("prompt waits", 0, host.late);
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic expect_str(input string s);
		int n;
		for (int i = 0; i < s.len(); i++) begin
			n = 0;
			while (host.rxq.size() == 0 && n < 400000) begin
				@(posedge clock);
				n++;
			end
			if (n >= 400000) begin
				miscompares++;
				$display("[ERR] serial char expected %0h seen none", s[i]);
				finish_test();
			end else begin
				chk("serial char", s[i], host.rxq.pop_front());
			end
		end
	endtask
	task automatic t_erase;
		bad_erase = 1'b1;
		host.send_byte("E");
		expect_str({"\r\nNot Erased", MENU});
		bad_erase = 1'b0;
		host.send_byte("e");
		expect_str({"\r\nErased", MENU});
		chk("flash low", 8'hFF, mem[16'h8000]);
		chk("flash high", 8'hFF, mem[16'hF7FF]);
		$display("test erase done");
	endtask
	task automatic t_program;
		host.send_byte("P");
		expect_str(STAR);
		host.send_line("S1058000AA55CB\r");
		expect_str(STAR);
		host.send_line("S105F7FE80008B\r");
		expect_str(STAR);
		host.send_line("\nS1048002BB00\n");
		expect_str(STAR);
		host.send_line("S9030000FC\r\n");
		expect_str(MENU);
		chk("byte 8000", 8'hAA, mem[16'h8000]);
		chk("byte 8001", 8'h55, mem[16'h8001]);
		chk("byte 8002", 8'hBB, mem[16'h8002]);
		chk("reset slot", 16'h8000, {mem[16'hF7FE], mem[16'hF7FF]});
		$display("test program done");
	endtask
	task automatic t_notprog;
		bad_prog = 16'h8010;
		host.send_byte("p");
		expect_str(STAR);
		host.send_line("S1048010CC00\r");
		expect_str({"\r\nNot Programmed", MENU});
		bad_prog = 16'h0000;
		$display("test not programmed done");
	endtask
	task automatic t_eeprom_load_selection;
		bad_erase = 1'b1;
		host.send_byte("L");
		expect_str({"\r\nNot Erased", MENU});
		bad_erase = 1'b0;
		mem[16'h0E00] = 8'h00;
		host.send_byte("L");
		expect_str(STAR);
		chk("eeprom erased", 8'hFF, mem[16'h0E00]);
		host.send_line("S1040D0012DC\r");
		expect_str(STAR);
		chk("eeprom byte", 8'h12, mem[16'h0D00]);
		host.send_line("S9030000FC\r");
		expect_str(MENU);
		$display("test load eeprom done");
	endtask
	task automatic t_escape;
		host.send_byte("l");
		expect_str(STAR);
		host.send_line("S1040D0134DC\r");
		expect_str(STAR);
		@(negedge clock);
		rst_n = 1'b0;
		repeat (16) @(negedge clock);
		rst_n = 1'b1;
		expect_str(MENU);
		chk("kept byte", 8'h34, mem[16'h0D01]);
		$display("test reset escape done");
	endtask
	initial begin
		for (int a = 0; a < 65536; a++) mem[a] = 8'h00;
		repeat (16) @(negedge clock);
		rst_n = 1'b1;
		expect_str(MENU);
		$display("test menu done");
		t_erase();
		t_program();
		t_notprog();
		t_eeprom_load_selection();
		t_escape();
		finish_test();
	end
endmodule
